// ---- design/wpc_irq.sv ----
// Sticky event status with mask and a single level interrupt output
`timescale 1ns/100ps

module wpc_irq #(
    parameter int N = 13
) (
    input  wire logic         clk,
    input  wire logic         srst,
    input  wire logic         ce,
    input  wire logic [N-1:0] event_in,   // One-cycle event pulses
    input  wire logic [N-1:0] mask,       // 1 lets a status bit raise the interrupt
    input  wire logic         read_clr,   // Status register read this cycle
    output logic      [N-1:0] status,     // Sticky status
    output logic              irq         // Level interrupt
);

    logic [N-1:0] status_q;  // Sticky bits
    logic [N-1:0] status_d;  // Next value

    // Read clears, but an event in the same cycle still sets its bit
    assign status_d = event_in | (read_clr ? '0 : status_q);

    // ======================================================================
    // Status register
    // ======================================================================
    always_ff @(posedge clk) begin
        if (srst) begin
            status_q <= '0;
        end else if (ce) begin
            status_q <= status_d;
        end
    end

    assign status = status_q;
    assign irq    = |(status_q & mask);

endmodule

// ---- design/wpc_pkg.sv ----
// Shared types for the wake and power configuration block
package wpc_pkg;

    // One bus word
    typedef logic [31:0] wpc_word_t;

    // Register selected by the current bus address
    typedef enum {
        WPC_SEL_NONE,
        WPC_SEL_EDGE,
        WPC_SEL_EN,
        WPC_SEL_CLR,
        WPC_SEL_STAT,
        WPC_SEL_REMAP,
        WPC_SEL_PWR,
        WPC_SEL_IRQ_STAT,
        WPC_SEL_IRQ_MASK,
        WPC_SEL_ID
    } wpc_sel_e;

endpackage

// ---- design/wpc_regs.svh ----
// Register offsets, field positions, reset values and widths for the wake and power registers
`ifndef WPC_REGS_SVH
`define WPC_REGS_SVH

// ==========================================================================
// Byte addresses
// ==========================================================================
`define WPC_ADDR_WAKE_EDGE   32'h40048200
`define WPC_ADDR_WAKE_EN     32'h40048204
`define WPC_ADDR_WAKE_CLR    32'h40048208
`define WPC_ADDR_WAKE_STAT   32'h4004820c
`define WPC_ADDR_REMAP_CFG   32'h40048234
`define WPC_ADDR_PWR_CTRL    32'h40048238
`define WPC_ADDR_IRQ_STAT    32'h40048300
`define WPC_ADDR_IRQ_MASK    32'h40048304
`define WPC_ADDR_PART_ID     32'h400483f4

// ==========================================================================
// Field positions and widths
// ==========================================================================
`define WPC_PIN_COUNT        11
`define WPC_SRC_COUNT        13
`define WPC_BIT_RF           11
`define WPC_BIT_TIMER        12
`define WPC_BIT_FLASH_OFF    0
`define WPC_PWR_WIDTH        6

// ==========================================================================
// Reset values
// ==========================================================================
`define WPC_RST_WAKE         13'h0000
`define WPC_RST_PWR          6'h3e
`define WPC_RST_WORD         32'h00000000

`endif

// ---- design/wpc_top.sv ----
// Wake-source status, flash remap, analog power-down and part ID register bank
//
// What this block does
// RL1: Bits 10:0 report latched port pin starts.
// RL2: Bit 11 RF start, bit 12 timer start.
// RL3: Only enabled sources may report a start.
// RL4: Remap flag set: whole flash maps to SRAM.
// RL5: Remap begins at deep sleep, ends on clear.
// RL6: Remap ignores the flash power-down bit.
// RL7: Power control writable anytime, acts immediately.
// RL8: Power bits: flash, temp, cap, nvm, current, pair.
// RL9: Flash powered at reset, others powered down.
// RL10: Software moves vectors, code to SRAM first.
// RL11: Part ID read-only, loaded during boot.
// RL12: Reserved status and power bits reset zero.
// RL13: Clear bit one resets latch, then zero.
// RL14: Pin edge chosen per bit: 0 fall, 1 rise.
// RL15: Reserved bits read zero, writes ignored.
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/100ps
`include "wpc_regs.svh"

module wpc_top
    import wpc_pkg::*;
#(
    parameter int N_PINS = `WPC_PIN_COUNT
) (
    input  wire logic                     clk,
    input  wire logic                     srst,
    input  wire logic                     ce,
    // Register port
    input  wire logic [31:0]              addr,
    input  wire logic [31:0]              wdata,
    input  wire logic                     wr,
    input  wire logic                     rd,
    output logic      [31:0]              rdata,
    // Wake sources
    input  wire logic [N_PINS-1:0]        port_pin_line,
    input  wire logic                     rf_wake_in,
    input  wire logic                     timer_wake_in,
    // Power mode and boot
    input  wire logic                     deep_sleep_enter,
    input  wire logic                     id_load_valid,
    input  wire logic [31:0]              id_load_data,
    // Outputs to the system
    output logic                          flash_remap_active,
    output logic      [`WPC_PWR_WIDTH-1:0] power_down,
    output logic                          irq
);

    localparam int NS = `WPC_SRC_COUNT;  // Pins plus RF plus timer

    // ======================================================================
    // Elaboration check
    // ======================================================================
    // The status layout puts RF and timer right above the pins, so the
    // pin count is fixed by the register map.
    if (N_PINS != `WPC_PIN_COUNT) begin : g_bad_pins
        $error("wpc_top: N_PINS must equal the fixed pin field width");
    end

    // ======================================================================
    // Registers
    // ======================================================================
    logic [NS-1:0]              edge_q;      // Edge select, only pin bits kept
    logic [NS-1:0]              edge_d;

    logic [NS-1:0]              en_q;        // Wake enables
    logic [NS-1:0]              en_d;

    logic [NS-1:0]              clr_q;       // Clear register as last written
    logic [NS-1:0]              clr_d;

    logic                       flag_q;      // Flash remap request flag
    logic                       flag_d;

    logic                       remap_q;     // Remap currently in force
    logic                       remap_d;

    logic [`WPC_PWR_WIDTH-1:0]  pwr_q;       // Analog power-down bits
    logic [`WPC_PWR_WIDTH-1:0]  pwr_d;

    logic [NS-1:0]              mask_q;      // Interrupt mask
    logic [NS-1:0]              mask_d;

    logic [31:0]                id_q;        // Part identification word
    logic [31:0]                id_d;

    logic [31:0]                rdata_q;     // Read data, valid one cycle
    logic [31:0]                rdata_d;

    // ======================================================================
    // Address decode
    // ======================================================================
    wpc_sel_e sel;
    assign sel = (addr == `WPC_ADDR_WAKE_EDGE) ? WPC_SEL_EDGE     :
                 (addr == `WPC_ADDR_WAKE_EN)   ? WPC_SEL_EN       :
                 (addr == `WPC_ADDR_WAKE_CLR)  ? WPC_SEL_CLR      :
                 (addr == `WPC_ADDR_WAKE_STAT) ? WPC_SEL_STAT     :
                 (addr == `WPC_ADDR_REMAP_CFG) ? WPC_SEL_REMAP    :
                 (addr == `WPC_ADDR_PWR_CTRL)  ? WPC_SEL_PWR      :
                 (addr == `WPC_ADDR_IRQ_STAT)  ? WPC_SEL_IRQ_STAT :
                 (addr == `WPC_ADDR_IRQ_MASK)  ? WPC_SEL_IRQ_MASK :
                 (addr == `WPC_ADDR_PART_ID)   ? WPC_SEL_ID       :
                                                 WPC_SEL_NONE;

    // Write strobes per register
    wire wr_edge  = wr & (sel == WPC_SEL_EDGE);
    wire wr_en    = wr & (sel == WPC_SEL_EN);
    wire wr_clr   = wr & (sel == WPC_SEL_CLR);
    wire wr_remap = wr & (sel == WPC_SEL_REMAP);
    wire wr_pwr   = wr & (sel == WPC_SEL_PWR);
    wire wr_mask  = wr & (sel == WPC_SEL_IRQ_MASK);

    // Reading the event status clears it
    wire rd_irqst = rd & (sel == WPC_SEL_IRQ_STAT);

    // ======================================================================
    // Wake sources and latches
    // ======================================================================
    wire [NS-1:0] src_line  = {timer_wake_in, rf_wake_in, port_pin_line};
    // RF and timer have no edge choice; they latch on the rising edge
    wire [NS-1:0] src_rise  = {2'b11, edge_q[N_PINS-1:0]};  // RL14

    // A written one clears its latch for that cycle
    wire [NS-1:0] clr_pulse = wr_clr ? wdata[NS-1:0] : '0;  // RL13
    wire [NS-1:0] seen;
    wire [NS-1:0] hit;

    wpc_wake_latch #(
        .N         (NS)
    ) u_latch (
        .clk       (clk),
        .srst      (srst),
        .ce        (ce),
        .line_in   (src_line),
        .edge_rise (src_rise),
        .enable    (en_q),
        .clear     (clr_pulse),
        .seen      (seen),
        .hit       (hit)
    );

    // Disabled sources are hidden from the status word
    // The latch refuses disabled sources too, so a late enable shows no old edge
    wire [NS-1:0] stat_view = seen & en_q;  // RL3

    // ======================================================================
    // Event interrupt
    // ======================================================================
    wire [NS-1:0] irq_status;

    wpc_irq #(
        .N        (NS)
    ) u_irq (
        .clk      (clk),
        .srst     (srst),
        .ce       (ce),
        .event_in (hit),
        .mask     (mask_q),
        .read_clr (rd_irqst & ce),
        .status   (irq_status),
        .irq      (irq)
    );

    // ======================================================================
    // Next-state values
    // ======================================================================
    // Only the pin bits of the edge register exist
    assign edge_d = wr_edge ? {2'b00, wdata[N_PINS-1:0]} : edge_q;  // RL15

    // Enable, clear and mask keep all thirteen source bits
    assign en_d   = wr_en   ? wdata[NS-1:0] : en_q;
    assign clr_d  = wr_clr  ? wdata[NS-1:0] : clr_q;
    assign mask_d = wr_mask ? wdata[NS-1:0] : mask_q;
    // Only the flag bit of the remap word is stored
    assign flag_d = wr_remap ? wdata[`WPC_BIT_FLASH_OFF] : flag_q;

    // Any write lands on the next edge, no lock or power-state check
    assign pwr_d  = wr_pwr ? wdata[`WPC_PWR_WIDTH-1:0] : pwr_q;  // RL7

    // Remap arms on deep-sleep entry and drops when the flag is cleared;
    // it never looks at the flash power-down bit
    assign remap_d = flag_q & (remap_q | deep_sleep_enter);  // RL5 RL6

    // Writes to the ID word are ignored; only the boot load changes it
    assign id_d   = id_load_valid ? id_load_data : id_q;  // RL11

    // ======================================================================
    // Read mux
    // ======================================================================
    wire [31:0] rd_mux =
        (sel == WPC_SEL_EDGE)     ? {19'h00000, edge_q}            :
        (sel == WPC_SEL_EN)       ? {19'h00000, en_q}              :
        (sel == WPC_SEL_CLR)      ? {19'h00000, clr_q}             :
        (sel == WPC_SEL_STAT)     ? {19'h00000, stat_view}         :  // RL1 RL2
        (sel == WPC_SEL_REMAP)    ? {31'h00000000, flag_q}         :
        (sel == WPC_SEL_PWR)      ? {26'h0000000, pwr_q}           :  // RL15
        (sel == WPC_SEL_IRQ_STAT) ? {19'h00000, irq_status}        :
        (sel == WPC_SEL_IRQ_MASK) ? {19'h00000, mask_q}            :
        (sel == WPC_SEL_ID)       ? id_q                           :
                                    32'h00000000;
    // Data stand only in the cycle after the strobe
    // A zero idle value lets the fabric OR the read data of several slaves
    assign rdata_d = rd ? rd_mux : 32'h00000000;

    // ======================================================================
    // Control registers
    // ======================================================================
    // Reserved and power bits take their reset constants
    always_ff @(posedge clk) begin
        if (srst) begin
            edge_q <= `WPC_RST_WAKE;
            en_q   <= `WPC_RST_WAKE;
            clr_q  <= `WPC_RST_WAKE;
            mask_q <= `WPC_RST_WAKE;
            flag_q <= 1'b0;
            pwr_q  <= `WPC_RST_PWR;  // RL9 RL12
        end else if (ce) begin
            edge_q <= edge_d;
            en_q   <= en_d;
            clr_q  <= clr_d;
            mask_q <= mask_d;
            flag_q <= flag_d;
            pwr_q  <= pwr_d;
        end
    end

    // Remap state, ID word and read data
    always_ff @(posedge clk) begin
        if (srst) begin
            remap_q <= 1'b0;
            id_q    <= `WPC_RST_WORD;
            rdata_q <= `WPC_RST_WORD;
        end else if (ce) begin
            remap_q <= remap_d;
            id_q    <= id_d;
            rdata_q <= rdata_d;
        end
    end

    // ======================================================================
    // Outputs
    // ======================================================================
    // Remap covers the full flash range, not just the vector table; the
    // bus fabric applies it to every flash address
    assign flash_remap_active = remap_q;  // RL4

    // Bit order: flash, temp sensor, cap conv, data nvm, current, pair;
    // software must move vectors and code to SRAM before setting bit 0
    assign power_down = pwr_q;  // RL8
    assign rdata      = rdata_q;

    // ======================================================================
    // Assertions
    // ======================================================================
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    // A read of the status word shows the enabled latches a cycle later
    status_read_a: assert property ( // RL1
        (ce && rd && sel == WPC_SEL_STAT) |=>
            (!ce || rdata[NS-1:0] == $past(seen & en_q))
    ) else $error("status word read does not match latches");

    // Bits 11 and 12 track the RF and timer latches
    rf_timer_bits_a: assert property ( // RL2
        (ce && rd && sel == WPC_SEL_STAT) |=>
            (!ce || rdata[`WPC_BIT_TIMER:`WPC_BIT_RF]
                    == $past(seen[`WPC_BIT_TIMER:`WPC_BIT_RF] & en_q[12:11]))
    ) else $error("RF or timer status bit wrong");

    // A disabled source never sets its latch
    disabled_hidden_a: assert property ( // RL3
        ce |=> ((seen & ~$past(en_q | seen)) == '0)
    ) else $error("disabled source reports a start");

    // Deep-sleep entry with the flag set turns remap on next cycle
    remap_start_a: assert property ( // RL4
        (ce && flag_q && deep_sleep_enter) |=> (!ce || flash_remap_active)
    ) else $error("remap did not start at deep-sleep entry");

    // Remap only rises on a deep-sleep entry
    remap_origin_a: assert property ( // RL5
        $rose(flash_remap_active) |-> $past(deep_sleep_enter && ce)
    ) else $error("remap started without deep-sleep entry");

    // Remap stays while the flag stays, whatever the flash power bit does
    remap_hold_a: assert property ( // RL6
        (ce && flash_remap_active && flag_q && !wr_remap) |=>
            (!ce || flash_remap_active)
    ) else $error("remap dropped while flag set");

    // A power write shows on the outputs on the next edge
    pwr_write_a: assert property ( // RL7
        (ce && wr_pwr) |=> (!ce || power_down == $past(wdata[5:0]))
    ) else $error("power write not applied immediately");

    // After reset flash is powered and the other blocks are down
    pwr_reset_a: assert property ( // RL9
        $fell(srst) |-> (power_down == 6'h3e)
    ) else $error("power-down reset value wrong");

    // The ID word changes only by a boot load
    id_readonly_a: assert property ( // RL11
        (ce && !srst && !id_load_valid) |=> (id_q == $past(id_q))
    ) else $error("part ID changed without a boot load");

    // A clear write drops the latch unless a new edge arrives
    clear_latch_a: assert property ( // RL13
        (ce && wr_clr && wdata[0] && !hit[0]) |=> !seen[0]
    ) else $error("clear did not reset the latch");

    // Falling edge selected on an enabled pin sets its latch
    edge_select_a: assert property ( // RL14
        (ce && en_q[0] && !edge_q[0] && !clr_pulse[0]
            && $past(port_pin_line[0]) && !port_pin_line[0]
            && $past(ce) && u_latch.armed_q) |=> seen[0]
    ) else $error("selected falling edge not latched");

    // Bits 31:13 of the status and power words read zero
    reserved_zero_a: assert property ( // RL12
        (rd && (sel == WPC_SEL_STAT || sel == WPC_SEL_PWR) && ce) |=>
            (rdata[31:13] == 19'h00000)
    ) else $error("reserved bits read nonzero");

    // An unmasked event raises the interrupt on the next cycle
    irq_raise_a: assert property (
        (ce && !srst && hit[0] && mask_q[0] && !wr_mask) |=> irq
    ) else $error("unmasked event did not raise the interrupt");

    // Read data return to zero in a cycle without a read
    rdata_idle_a: assert property (
        (ce && !rd) |=> (rdata == 32'h00000000)
    ) else $error("read data not zero outside a read answer");

    // Main scenarios
    pin_wake_c:   cover property (hit[0] ##[1:20] (rd && sel == WPC_SEL_STAT));
    remap_c:      cover property ($rose(flash_remap_active) ##[1:50] $fell(flash_remap_active));
    irq_c:        cover property ($rose(irq) ##[1:20] rd_irqst);
    pwr_flash_c:  cover property (wr_pwr && wdata[0]);

endmodule

// ---- design/wpc_wake_latch.sv ----
// Per-source edge detector and sticky start latch for the wake sources
`timescale 1ns/100ps

module wpc_wake_latch #(
    parameter int N = 13
) (
    input  wire logic         clk,
    input  wire logic         srst,
    input  wire logic         ce,
    input  wire logic [N-1:0] line_in,    // Source levels, synchronous to clk
    input  wire logic [N-1:0] edge_rise,  // 1 rising edge, 0 falling edge
    input  wire logic [N-1:0] enable,     // Source enables
    input  wire logic [N-1:0] clear,      // One-cycle clear pulses
    output logic      [N-1:0] seen,       // Latched start state
    output logic      [N-1:0] hit         // One-cycle pulse on a new accepted edge
);

    logic armed_q;  // Blocks a false edge on the first sample after reset

    // ======================================================================
    // Arming flop
    // ======================================================================
    always_ff @(posedge clk) begin
        if (srst) begin
            armed_q <= 1'b0;
        end else if (ce) begin
            armed_q <= 1'b1;
        end
    end

    // ======================================================================
    // One latch per source
    // ======================================================================
    for (genvar i = 0; i < N; i++) begin : g_src
        logic prev_q;                         // Previous level of the line
        logic seen_q;                         // Sticky start state
        wire  rise = line_in[i] & ~prev_q;    // Rising edge this cycle
        wire  fall = ~line_in[i] & prev_q;    // Falling edge this cycle
        // Edge of the selected polarity on an enabled source only
        wire  take = armed_q & enable[i] & (edge_rise[i] ? rise : fall);

        // Previous level follows the line; reset to a constant
        always_ff @(posedge clk) begin
            if (srst) begin
                prev_q <= 1'b0;
            end else if (ce) begin
                prev_q <= line_in[i];
            end
        end

        // New edge wins over a clear in the same cycle
        always_ff @(posedge clk) begin
            if (srst) begin
                seen_q <= 1'b0;
            end else if (ce) begin
                seen_q <= take | (seen_q & ~clear[i]);
            end
        end

        assign seen[i] = seen_q;
        assign hit[i]  = take & ce;
    end

endmodule

// ---- verif/wpc_top_tb.sv ----
// Self-checking bench for the wake and power configuration register bank
`timescale 1ns/100ps
`include "wpc_regs.svh"

module wpc_top_tb
    import wpc_pkg::*;
;
    // ======================================================================
    // Signals
    // ======================================================================
    localparam wpc_word_t ID_VAL = 32'h5a17c0de; // Arbitrary part code
    logic        clk, srst, ce, wr, rd, rf_wake_in, timer_wake_in;
    logic        deep_sleep_enter, id_load_valid, flash_remap_active, irq;
    logic [31:0] addr, wdata, rdata, id_load_data;
    logic [10:0] port_pin_line;  // Pin levels driven by the bench
    logic [5:0]  power_down;
    logic        rd_p = 1'b0;    // A read answer is due this cycle
    int          bad_count, total_checks, seed;
    wpc_word_t   exp_q[$];       // Expected read data, oldest first
    string       nm_q[$];        // Names of the pending reads
    logic [12:0] edge_v, en_v;   // Random edge and enable settings
    wpc_word_t   pwr_v;

    wpc_top uut (.clk(clk), .srst(srst), .ce(ce), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .port_pin_line(port_pin_line),
        .rf_wake_in(rf_wake_in), .timer_wake_in(timer_wake_in),
        .deep_sleep_enter(deep_sleep_enter), .id_load_valid(id_load_valid),
        .id_load_data(id_load_data), .flash_remap_active(flash_remap_active),
        .power_down(power_down), .irq(irq));

    // ======================================================================
    // Clock, compare and closing
    // ======================================================================
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Case inequality so an unknown never passes
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Guard against a hang anywhere in the sequence
    initial begin
        #200000;
        bad_count++;
        end_of_test();
    end

    // ======================================================================
    // Read monitor: answer stands one cycle after the strobe, 0 otherwise
    // ======================================================================
    always @(posedge clk) rd_p <= rd & ce & ~srst;
    always @(negedge clk) begin
        if (rd_p === 1'b1) begin
            if (exp_q.size() == 0) begin
                chk("unexpected_read", 32'h1, 32'h0);
            end else begin
                chk(nm_q.pop_front(), rdata, exp_q.pop_front());
            end
        end else if (srst === 1'b0) begin
            chk("rdata_idle", rdata, 32'h0);
        end
    end

    // ======================================================================
    // Bus tasks: each starts on a fresh edge so strobes never collide
    // ======================================================================
    task automatic wr_reg(input wpc_word_t a, input wpc_word_t d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask

    task automatic rd_exp(input string nm, input wpc_word_t a, input wpc_word_t e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        exp_q.push_back(e);
        nm_q.push_back(nm);
        @(posedge clk);
        rd <= 1'b0;
        #1;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // ======================================================================
    // Main sequence
    // ======================================================================
    initial begin
        seed = 32'h4b83;
        edge_v = 13'($random(seed));
        en_v = 13'($random(seed)) | 13'h0801;  // At least one pin and RF enabled
        pwr_v = $random(seed) & 32'hfffffffe;
        {srst, ce, wr, rd, addr, wdata} = {1'b1, 1'b1, 1'b0, 1'b0, 64'h0};
        port_pin_line = edge_v[10:0];  // First toggle is then the wrong edge
        {rf_wake_in, timer_wake_in, deep_sleep_enter, id_load_valid} = 4'h0;
        id_load_data = ID_VAL;
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        #1;
        chk("power_down_rst", {26'h0, power_down}, 32'h3e);
        rd_exp("pwr_rst", `WPC_ADDR_PWR_CTRL, 32'h3e);
        rd_exp("stat_rst", `WPC_ADDR_WAKE_STAT, 32'h0);
        rd_exp("remap_rst", `WPC_ADDR_REMAP_CFG, 32'h0);
        rd_exp("id_rst", `WPC_ADDR_PART_ID, 32'h0);
        // Power control: random word, reserved bits dropped, acts at once
        wr_reg(`WPC_ADDR_PWR_CTRL, pwr_v);
        chk("power_down", {26'h0, power_down}, {26'h0, pwr_v[5:0]});
        rd_exp("pwr_rd", `WPC_ADDR_PWR_CTRL, {26'h0, pwr_v[5:0]});
        // Frozen clock enable ignores a write
        @(posedge clk) ce <= 1'b0;
        wr_reg(`WPC_ADDR_PWR_CTRL, ~pwr_v);
        @(posedge clk) ce <= 1'b1;
        rd_exp("pwr_frozen", `WPC_ADDR_PWR_CTRL, {26'h0, pwr_v[5:0]});
        // Part code: loaded by boot, bus writes ignored
        @(posedge clk) id_load_valid <= 1'b1;
        @(posedge clk) id_load_valid <= 1'b0;
        wr_reg(`WPC_ADDR_PART_ID, ~ID_VAL);
        rd_exp("part_id", `WPC_ADDR_PART_ID, ID_VAL);
        wr_reg(32'h40048100, 32'hffffffff);
        rd_exp("unmapped", 32'h40048100, 32'h0);
        // Wake sources: edge select, enable, mask
        wr_reg(`WPC_ADDR_WAKE_EDGE, {19'h0, edge_v});
        rd_exp("edge_rd", `WPC_ADDR_WAKE_EDGE, {21'h0, edge_v[10:0]});
        wr_reg(`WPC_ADDR_WAKE_EN, {19'h0, en_v});
        wr_reg(`WPC_ADDR_IRQ_MASK, 32'h1f0f);
        rd_exp("en_rd", `WPC_ADDR_WAKE_EN, {19'h0, en_v});
        rd_exp("mask_rd", `WPC_ADDR_IRQ_MASK, 32'h1f0f);
        @(posedge clk) port_pin_line <= ~port_pin_line;  // Opposite edges
        cyc(3);
        rd_exp("stat_wrong_edge", `WPC_ADDR_WAKE_STAT, 32'h0);
        chk("irq_idle", {31'h0, irq}, 32'h0);
        @(posedge clk) port_pin_line <= ~port_pin_line;  // Selected edges
        rf_wake_in <= 1'b1;
        timer_wake_in <= 1'b1;
        cyc(3);
        rd_exp("stat_seen", `WPC_ADDR_WAKE_STAT, {19'h0, en_v});
        chk("irq_set", {31'h0, irq}, {31'h0, |(en_v & 13'h1f0f)});
        rd_exp("irq_stat", `WPC_ADDR_IRQ_STAT, {19'h0, en_v});
        rd_exp("irq_stat_clr", `WPC_ADDR_IRQ_STAT, 32'h0);
        cyc(1);
        chk("irq_clr", {31'h0, irq}, 32'h0);
        // Clear latches with ones, then back to zero
        wr_reg(`WPC_ADDR_WAKE_CLR, {19'h0, en_v});
        wr_reg(`WPC_ADDR_WAKE_CLR, 32'h0);
        rd_exp("clr_rd", `WPC_ADDR_WAKE_CLR, 32'h0);
        rd_exp("stat_cleared", `WPC_ADDR_WAKE_STAT, 32'h0);
        // Remap: flag alone does nothing until deep sleep is entered
        wr_reg(`WPC_ADDR_PWR_CTRL, 32'h0);
        wr_reg(`WPC_ADDR_REMAP_CFG, 32'hffffffff);
        rd_exp("remap_rd", `WPC_ADDR_REMAP_CFG, 32'h1);
        chk("remap_early", {31'h0, flash_remap_active}, 32'h0);
        @(posedge clk) deep_sleep_enter <= 1'b1;
        @(posedge clk) deep_sleep_enter <= 1'b0;
        #1;
        chk("remap_on", {31'h0, flash_remap_active}, 32'h1);
        wr_reg(`WPC_ADDR_PWR_CTRL, 32'h1);
        cyc(3);
        chk("remap_held", {31'h0, flash_remap_active}, 32'h1);
        wr_reg(`WPC_ADDR_REMAP_CFG, 32'h0);
        cyc(2);
        chk("remap_off", {31'h0, flash_remap_active}, 32'h0);
        @(posedge clk) deep_sleep_enter <= 1'b1;
        @(posedge clk) deep_sleep_enter <= 1'b0;
        cyc(1);
        chk("remap_no_flag", {31'h0, flash_remap_active}, 32'h0);
        // Reset in mid-run restores the power defaults
        @(posedge clk) srst <= 1'b1;
        @(posedge clk) srst <= 1'b0;
        #1;
        chk("power_down_rst2", {26'h0, power_down}, 32'h3e);
        rd_exp("pwr_rst2", `WPC_ADDR_PWR_CTRL, 32'h3e);
        cyc(2);
        chk("reads_pending", exp_q.size(), 32'h0);
        end_of_test();
    end
endmodule
